// [rtl/tdg_pkg.sv]
`default_nettype none
package tdg_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] TDG_REG_DESC_BASE = 8'h00;
	localparam logic [7:0] TDG_REG_DONE_BASE = 8'h04;
	localparam logic [7:0] TDG_REG_CH_SEL = 8'h08;
	localparam logic [7:0] TDG_REG_CH_CFG = 8'h0C;
	localparam logic [7:0] TDG_REG_STATUS = 8'h10;
	localparam int TDG_CFG_ACTIVE_BIT = 0;
	localparam int TDG_CFG_DQS_BIT = 1;

	// ----------------------------------------
	// Descriptor layout
	// ----------------------------------------
	localparam int TDG_D1_EOF_BIT = 31;
	localparam int TDG_D1_CHAIN_BIT = 30;
	localparam int TDG_D1_BC_LSB = 16;
	localparam int TDG_D1_BC_W = 13;
	localparam int TDG_D3_PV_BIT = 16;
	localparam logic [1:0] TDG_WORD_ADDR = 2'h0;
	localparam logic [1:0] TDG_WORD_CTRL = 2'h1;
	localparam logic [1:0] TDG_WORD_CHAN = 2'h2;
	localparam logic [1:0] TDG_WORD_LINK = 2'h3;
	localparam logic [1:0] TDG_MAX_INTERNAL = 2'h2;

	// ----------------------------------------
	// Done status codes
	// ----------------------------------------
	localparam logic [2:0] TDG_ST_PKT_OK = 3'h0;
	localparam logic [2:0] TDG_ST_BUF_FIRST = 3'h1;
	localparam logic [2:0] TDG_ST_BUF_MID = 3'h2;
	localparam logic [2:0] TDG_ST_BUF_LAST = 3'h3;
	localparam logic [2:0] TDG_ST_DISABLED = 3'h4;
	localparam logic [2:0] TDG_ST_DESC_ERR = 3'h5;
	localparam logic [2:0] TDG_ST_ABORT = 3'h6;
	localparam logic [2:0] TDG_ST_UNDERFLOW = 3'h7;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		TDG_SEL = 3'h0,
		TDG_FETCH = 3'h1,
		TDG_CHECK = 3'h3,
		TDG_XMIT = 3'h2,
		TDG_POST = 3'h6,
		TDG_LINK_RD = 3'h7,
		TDG_LINK_WR = 3'h5
	} tdg_st_e;

	typedef struct packed {
		logic [2:0] status;
		logic channel_restart_request;
		logic urgent_flag;
		logic [7:0] chan;
		logic [15:0] ptr;
	} tdg_entry_s;

	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} tdg_mreq_s;

	typedef struct packed {
		logic ack;
		logic abort;
		logic [31:0] rdata;
	} tdg_mrsp_s;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [12:0] bcount;
		logic [7:0] chan;
	} tdg_xmit_s;

	typedef struct packed {
		logic [1:0] n;
		logic [15:0] cur;
		logic [15:0] first;
		logic [15:0] sec;
		logic [15:0] tail;
		logic [7:0] chan;
		logic chk;
		logic [7:0] sec_chan;
		logic sec_chk;
	} tdg_q_s;
endpackage
`default_nettype wire

// [rtl/tdg_tx_dma.sv]
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module tdg_tx_dma
	import tdg_pkg::*;
#(
	parameter int N_CHAN = 256
)
(
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic pend_valid_in,
	input wire tdg_entry_s pend_entry_in,
	output logic pend_ready_out,
	output tdg_mreq_s mem_req_out,
	input wire tdg_mrsp_s mem_rsp_in,
	output tdg_xmit_s xmit_out,
	input wire logic xmit_done_in,
	input wire logic xmit_underflow_in
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// One flag per 8-bit channel code
	if (N_CHAN != 256) begin : g_chan_chk
		$error("channel flags must cover the 8-bit code");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		tdg_st_e st;
		logic [31:0] desc_base;
		logic [31:0] done_base;
		logic [7:0] sel;
		logic [N_CHAN-1:0] act;
		logic [N_CHAN-1:0] dqs;
		tdg_q_s [1:0] q;
		logic cls;
		logic first_buf;
		logic [15:0] cur_ptr;
		logic [1:0] wi;
		logic [31:0] d1;
		logic [7:0] dch;
		logic [7:0] ch;
		logic [2:0] err;
		logic [15:0] done_idx;
		tdg_mreq_s mreq;
		tdg_xmit_s xm;
		logic [31:0] rdata;
	} tdg_core_s;

	tdg_core_s s_r;
	tdg_core_s s_nxt;
	logic eof;
	logic chain;
	logic [12:0] bc;
	logic busy;
	logic need_post;
	logic [2:0] ok_code;

	// ----------------------------------------
	// Descriptor addressing
	// ----------------------------------------
	function automatic logic [31:0] desc_addr(input logic [31:0] base,
			input logic [15:0] ptr, input logic [1:0] w);
		desc_addr = base + {12'h000, ptr, w, 2'b00};
	endfunction

	// ----------------------------------------
	// Decoded fields
	// ----------------------------------------
	// Control dword fields, queue busy flag and done post decision
	assign eof = s_r.d1[TDG_D1_EOF_BIT];
	assign chain = s_r.d1[TDG_D1_CHAIN_BIT];
	assign bc = s_r.d1[TDG_D1_BC_LSB +: TDG_D1_BC_W];
	assign busy = (s_r.q[0].n != 2'h0) || (s_r.q[1].n != 2'h0);
	assign need_post = (s_r.err != TDG_ST_PKT_OK) || s_r.dqs[s_r.ch]
		|| eof;

	// ----------------------------------------
	// Pending intake handshake
	// ----------------------------------------
	// Restart held while busy
	assign pend_ready_out = (s_r.st == TDG_SEL)
		&& !(pend_entry_in.channel_restart_request && busy);

	// ----------------------------------------
	// Done status
	// ----------------------------------------
	// Done select code
	always_comb begin
		if (!s_r.dqs[s_r.ch]) begin
			ok_code = TDG_ST_PKT_OK;
		end else if (eof) begin
			ok_code = TDG_ST_BUF_LAST;
		end else if (s_r.first_buf) begin
			ok_code = TDG_ST_BUF_FIRST;
		end else begin
			ok_code = TDG_ST_BUF_MID;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = 32'h0000_0000;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				TDG_REG_DESC_BASE: s_nxt.rdata = s_r.desc_base;
				TDG_REG_DONE_BASE: s_nxt.rdata = s_r.done_base;
				TDG_REG_CH_SEL: s_nxt.rdata = {24'h000000, s_r.sel};
				TDG_REG_CH_CFG: s_nxt.rdata = {30'h0000_0000,
					s_r.dqs[s_r.sel], s_r.act[s_r.sel]};
				TDG_REG_STATUS: s_nxt.rdata = {9'h000, s_r.st,
					s_r.q[1].n, s_r.q[0].n, s_r.done_idx};
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				TDG_REG_DESC_BASE: s_nxt.desc_base = reg_wdata_in;
				TDG_REG_DONE_BASE: s_nxt.done_base = reg_wdata_in;
				TDG_REG_CH_SEL: s_nxt.sel = reg_wdata_in[7:0];
				TDG_REG_CH_CFG: begin
					s_nxt.act[s_r.sel] = reg_wdata_in[TDG_CFG_ACTIVE_BIT];
					s_nxt.dqs[s_r.sel] = reg_wdata_in[TDG_CFG_DQS_BIT];
				end
				default: begin
				end
			endcase
		end
		unique case (s_r.st)
			TDG_SEL: begin
				s_nxt.first_buf = 1'b1;
				s_nxt.err = TDG_ST_PKT_OK;
				if (pend_valid_in && pend_ready_out) begin
					if (pend_entry_in.channel_restart_request) begin
						s_nxt.act[pend_entry_in.chan] = 1'b1;
					end
					s_nxt.cls = pend_entry_in.urgent_flag;
					if (s_r.q[pend_entry_in.urgent_flag].n == 2'h0) begin
						s_nxt.q[pend_entry_in.urgent_flag].cur = pend_entry_in.ptr;
						s_nxt.q[pend_entry_in.urgent_flag].first =
							pend_entry_in.ptr;
						s_nxt.q[pend_entry_in.urgent_flag].tail = pend_entry_in.ptr;
						s_nxt.q[pend_entry_in.urgent_flag].chan = pend_entry_in.chan;
						s_nxt.q[pend_entry_in.urgent_flag].chk = 1'b1;
						s_nxt.q[pend_entry_in.urgent_flag].n = 2'h1;
					end else if (s_r.q[pend_entry_in.urgent_flag].n
							!= TDG_MAX_INTERNAL) begin
						s_nxt.q[pend_entry_in.urgent_flag].sec = pend_entry_in.ptr;
						s_nxt.q[pend_entry_in.urgent_flag].sec_chan =
							pend_entry_in.chan;
						s_nxt.q[pend_entry_in.urgent_flag].sec_chk = 1'b1;
						s_nxt.q[pend_entry_in.urgent_flag].tail = pend_entry_in.ptr;
						s_nxt.q[pend_entry_in.urgent_flag].n = TDG_MAX_INTERNAL;
					end else begin
						s_nxt.cur_ptr = pend_entry_in.ptr;
						s_nxt.mreq.req = 1'b1;
						s_nxt.mreq.we = 1'b1;
						s_nxt.mreq.addr = desc_addr(s_r.desc_base,
							s_r.q[pend_entry_in.urgent_flag].tail, TDG_WORD_LINK);
						s_nxt.mreq.wdata = {15'h0000, 1'b1, pend_entry_in.ptr};
						s_nxt.st = TDG_LINK_WR;
					end
				end else if (s_r.q[1].n != 2'h0 || s_r.q[0].n != 2'h0) begin
					s_nxt.cls = (s_r.q[1].n != 2'h0);
					s_nxt.cur_ptr = s_nxt.cls ? s_r.q[1].cur : s_r.q[0].cur;
					s_nxt.wi = TDG_WORD_ADDR;
					s_nxt.mreq.req = 1'b1;
					s_nxt.mreq.we = 1'b0;
					s_nxt.mreq.addr = desc_addr(s_r.desc_base, s_nxt.cur_ptr,
						TDG_WORD_ADDR);
					s_nxt.st = TDG_FETCH;
				end
			end
			TDG_LINK_WR: begin
				if (mem_rsp_in.ack) begin
					s_nxt.mreq.req = 1'b0;
					s_nxt.q[s_r.cls].tail = s_r.cur_ptr;
					s_nxt.st = TDG_SEL;
				end
			end
			TDG_FETCH: begin
				if (mem_rsp_in.ack) begin
					s_nxt.mreq.req = 1'b0;
					if (mem_rsp_in.abort) begin
						s_nxt.err = TDG_ST_ABORT;
						s_nxt.ch = s_r.q[s_r.cls].chan;
						s_nxt.act[s_r.q[s_r.cls].chan] = 1'b0;
						s_nxt.st = TDG_POST;
					end else begin
						unique case (s_r.wi)
							TDG_WORD_ADDR: s_nxt.xm.addr = mem_rsp_in.rdata;
							TDG_WORD_CTRL: s_nxt.d1 = mem_rsp_in.rdata;
							default: s_nxt.dch = mem_rsp_in.rdata[7:0];
						endcase
						if (s_r.wi == TDG_WORD_CHAN) begin
							s_nxt.st = TDG_CHECK;
						end else begin
							s_nxt.wi = s_r.wi + 2'h1;
							s_nxt.mreq.req = 1'b1;
							s_nxt.mreq.addr = desc_addr(s_r.desc_base,
								s_r.cur_ptr, s_nxt.wi);
						end
					end
				end
			end
			TDG_CHECK: begin
				s_nxt.ch = s_r.q[s_r.cls].chk ? s_r.q[s_r.cls].chan : s_r.dch;
				s_nxt.st = TDG_POST;
				if (!s_r.act[s_nxt.ch]) begin
					s_nxt.err = TDG_ST_DISABLED;
				end else if ((s_r.q[s_r.cls].chk
						&& s_r.q[s_r.cls].chan != s_r.dch)
						|| bc == 13'h0000) begin
					s_nxt.err = TDG_ST_DESC_ERR;
					s_nxt.act[s_nxt.ch] = 1'b0;
				end else begin
					s_nxt.xm.valid = 1'b1;
					s_nxt.xm.bcount = bc;
					s_nxt.xm.chan = s_nxt.ch;
					s_nxt.st = TDG_XMIT;
				end
			end
			TDG_XMIT: begin
				if (xmit_underflow_in) begin
					s_nxt.act[s_r.ch] = 1'b0;
					s_nxt.err = TDG_ST_UNDERFLOW;
					s_nxt.xm.valid = 1'b0;
					s_nxt.st = TDG_POST;
				end else if (xmit_done_in) begin
					s_nxt.xm.valid = 1'b0;
					s_nxt.st = TDG_POST;
				end
			end
			TDG_POST: begin
				if (need_post && !s_r.mreq.req) begin
					s_nxt.mreq.req = 1'b1;
					s_nxt.mreq.we = 1'b1;
					s_nxt.mreq.addr = s_r.done_base
						+ {14'h0000, s_r.done_idx, 2'b00};
					s_nxt.mreq.wdata = {3'h0,
						(s_r.err != TDG_ST_PKT_OK) ? s_r.err : ok_code,
						2'b00, s_r.ch, s_r.cur_ptr};
				end else if (!need_post || mem_rsp_in.ack) begin
					s_nxt.mreq.req = 1'b0;
					if (need_post) begin
						s_nxt.done_idx = s_r.done_idx + 16'h0001;
					end
					s_nxt.first_buf = 1'b0;
					if (s_r.err != TDG_ST_ABORT && !eof) begin
						s_nxt.cur_ptr = s_r.d1[15:0];
						s_nxt.q[s_r.cls].cur = s_r.d1[15:0];
						s_nxt.wi = TDG_WORD_ADDR;
						s_nxt.mreq.req = 1'b1;
						s_nxt.mreq.we = 1'b0;
						s_nxt.mreq.addr = desc_addr(s_r.desc_base,
							s_r.d1[15:0], TDG_WORD_ADDR);
						s_nxt.err = TDG_ST_PKT_OK;
						s_nxt.st = TDG_FETCH;
					end else if (s_r.err != TDG_ST_ABORT && chain) begin
						s_nxt.q[s_r.cls].cur = s_r.d1[15:0];
						s_nxt.st = TDG_SEL;
					end else if (s_r.q[s_r.cls].n == TDG_MAX_INTERNAL) begin
						s_nxt.q[s_r.cls].cur = s_r.q[s_r.cls].sec;
						s_nxt.q[s_r.cls].first = s_r.q[s_r.cls].sec;
						s_nxt.q[s_r.cls].chan = s_r.q[s_r.cls].sec_chan;
						s_nxt.q[s_r.cls].chk = s_r.q[s_r.cls].sec_chk;
						s_nxt.q[s_r.cls].n = 2'h1;
						s_nxt.mreq.req = 1'b1;
						s_nxt.mreq.we = 1'b0;
						s_nxt.mreq.addr = desc_addr(s_r.desc_base,
							s_r.q[s_r.cls].sec, TDG_WORD_LINK);
						s_nxt.st = TDG_LINK_RD;
					end else begin
						s_nxt.q[s_r.cls].n = 2'h0;
						s_nxt.st = TDG_SEL;
					end
				end
			end
			TDG_LINK_RD: begin
				if (mem_rsp_in.ack) begin
					s_nxt.mreq.req = 1'b0;
					if (!mem_rsp_in.abort
							&& mem_rsp_in.rdata[TDG_D3_PV_BIT]) begin
						s_nxt.q[s_r.cls].sec = mem_rsp_in.rdata[15:0];
						s_nxt.q[s_r.cls].sec_chk = 1'b0;
						s_nxt.q[s_r.cls].n = TDG_MAX_INTERNAL;
					end
					s_nxt.st = TDG_SEL;
				end
			end
			default: s_nxt.st = TDG_SEL;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_out = s_r.rdata;
	assign mem_req_out = s_r.mreq;
	assign xmit_out = s_r.xm;
endmodule // tdg_tx_dma
`default_nettype wire

// [sim/tdg_tx_dma_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module tdg_tx_dma_chk
	import tdg_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic pend_ready_out,
	input wire tdg_mreq_s mem_req_out,
	input wire tdg_mrsp_s mem_rsp_in,
	input wire tdg_xmit_s xmit_out,
	input wire logic xmit_done_in,
	input wire logic xmit_underflow_in
);
	// ----------------
	// Port checks
	// ----------------
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	sequence fault_s;
		xmit_out.valid && xmit_underflow_in;
	endsequence
	sequence post_s;
		mem_req_out.req && mem_req_out.we && mem_req_out.wdata[28:26] == 3'h7;
	endsequence
	req_hold_a: assert property (
		mem_req_out.req && !mem_rsp_in.ack |=> $stable(mem_req_out))
		else $error("memory request moved before ack");
	uf_post_a: assert property (
		fault_s |-> ##[1:60] post_s)
		else $error("underflow not posted");
	xmit_hold_a: assert property (
		xmit_out.valid && !xmit_done_in && !xmit_underflow_in
		|=> $stable(xmit_out))
		else $error("buffer changed while sending");
	xmit_end_a: assert property (
		xmit_out.valid && (xmit_done_in || xmit_underflow_in)
		|=> !xmit_out.valid)
		else $error("buffer not released");
	zero_cnt_a: assert property (
		xmit_out.valid |-> xmit_out.bcount != 13'h0)
		else $error("empty buffer sent");
	rd_idle_a: assert property (
		!reg_rd_in |=> reg_rdata_out == 32'h0)
		else $error("read data without read");
	addr_align_a: assert property (
		mem_req_out.req |-> mem_req_out.addr[1:0] == 2'h0)
		else $error("unaligned memory access");
	ready_init_a: assert property (
		$fell(reset_in) |-> pend_ready_out)
		else $error("intake closed after reset");
endmodule // tdg_tx_dma_chk
bind tdg_tx_dma tdg_tx_dma_chk u_chk (
	.core_clk_in(core_clk_in),
	.reset_in(reset_in),
	.reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.pend_ready_out(pend_ready_out),
	.mem_req_out(mem_req_out),
	.mem_rsp_in(mem_rsp_in),
	.xmit_out(xmit_out),
	.xmit_done_in(xmit_done_in),
	.xmit_underflow_in(xmit_underflow_in)
);
`default_nettype wire

// [sim/tdg_host_mem.sv]
`timescale 1ns/100ps
`default_nettype none
module tdg_host_mem
	import tdg_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire tdg_mreq_s mem_req_in,
	input wire logic abort_in,
	output tdg_mrsp_s mem_rsp_out
);
	logic [31:0] mem [0:1023];
	logic [31:0] data_r;
	logic ack_r;
	logic abort_r;
	logic slow_r;
	logic [1:0] lat_r;
	int n_done;
	// ----------------
	// Memory slave
	// ----------------
	// Idle data lines toggle
	assign mem_rsp_out = '{ack_r, abort_r, ack_r ? data_r : ~data_r};
	always @(posedge core_clk_in) begin
		ack_r <= 1'b0;
		if (reset_in) begin
			lat_r <= 2'h0;
			slow_r <= 1'b0;
			n_done <= 0;
		end else if (mem_req_in.req && !ack_r) begin
			if (lat_r == {slow_r, slow_r}) begin
				lat_r <= 2'h0;
				slow_r <= !slow_r;
				ack_r <= 1'b1;
				abort_r <= abort_in && !mem_req_in.we;
				data_r <= mem[mem_req_in.addr[11:2]];
				if (mem_req_in.we) begin
					mem[mem_req_in.addr[11:2]] <= mem_req_in.wdata;
					n_done <= n_done + (mem_req_in.addr[11] ? 1 : 0);
				end
			end else begin
				lat_r <= lat_r + 2'h1;
			end
		end
	end
endmodule // tdg_host_mem
`default_nettype wire

// [sim/tdg_tx_dma_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tdg_tx_dma_tb
	import tdg_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic pvld = 1'b0;
	logic done = 1'b0;
	logic uf = 1'b0;
	logic ufm = 1'b0;
	logic abm = 1'b0;
	logic prdy;
	logic [7:0] ra = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	tdg_entry_s pe = '0;
	tdg_mreq_s mq;
	tdg_mrsp_s ms;
	tdg_xmit_s xo;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int wc = 0;
	logic [31:0] sent [$];
	logic [2:0] est [5] = '{3'h4, 3'h5, 3'h5, 3'h6, 3'h7};
	int ord [5] = '{5, 7, 8, 9, 6};
	initial begin
		forever #5 clk = ~clk;
	end
	tdg_tx_dma dut (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(ra),
		.reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdat), .pend_valid_in(pvld), .pend_entry_in(pe),
		.pend_ready_out(prdy), .mem_req_out(mq), .mem_rsp_in(ms),
		.xmit_out(xo), .xmit_done_in(done), .xmit_underflow_in(uf));
	tdg_host_mem u_mem (.core_clk_in(clk), .reset_in(rst), .mem_req_in(mq),
		.abort_in(abm), .mem_rsp_out(ms));
	// ----------------
	// Transmit FIFO and timeout
	// ----------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			$display("CHECK FAILED at %0t: timeout", $time);
			conclude();
		end
	end
	always @(posedge clk) begin
		done <= 1'b0;
		uf <= 1'b0;
		if (xo.valid && !done && !uf) begin
			wc <= (wc == 3) ? 0 : wc + 1;
			if (wc == 3 && ufm) uf <= 1'b1;
			if (wc == 3 && !ufm) begin
				chk(32'({xo.chan, xo.bcount}), 32'h2004);
				done <= 1'b1;
				sent.push_back(xo.addr);
			end
		end
	end
	// ----------------
	// Tasks
	// ----------------
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rreg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		ra <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdat, e);
	endtask
	function logic [31:0] ba(input int i);
		return 32'h1000 + 32'(i) * 32'h100;
	endfunction
	task desc(input int i, input logic [31:0] ctl);
		u_mem.mem[i * 4] = ba(i);
		u_mem.mem[i * 4 + 1] = ctl;
		u_mem.mem[i * 4 + 2] = 32'h1;
		u_mem.mem[i * 4 + 3] = 32'h0;
	endtask
	task push(input logic [15:0] p, input logic u, input logic r,
		input logic [7:0] c);
		pvld <= 1'b1;
		pe <= '{3'h0, r, u, c, p};
		do @(negedge clk); while (!prdy);
		@(posedge clk);
	endtask
	task waitd(input int k, input logic [2:0] st);
		while (u_mem.n_done <= k) @(posedge clk);
		#1;
		chk({29'h0, u_mem.mem[512 + k][28:26]}, {29'h0, st});
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ----------------
	// Tests
	// ----------------
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rreg(TDG_REG_CH_CFG, 32'h0);
		wreg(TDG_REG_DESC_BASE, 32'h0);
		wreg(TDG_REG_DONE_BASE, 32'h800);
		wreg(TDG_REG_CH_SEL, 32'h1);
		wreg(TDG_REG_CH_CFG, 32'h1);
		rreg(TDG_REG_CH_CFG, 32'h1);
		rreg(8'h20, 32'h0);
		for (int i = 3; i < 10; i++) desc(i, 32'h80040000);
		desc(0, 32'h40040001);
		desc(1, 32'h00040002);
		desc(2, 32'hC0040004);
		desc(4, 32'h80040000);
		desc(5, 32'hC0040006);
		@(posedge clk);
		push(16'h0, 1'b0, 1'b0, 8'h1);
		pvld <= 1'b0;
		waitd(0, 3'h0);
		waitd(1, 3'h0);
		chk(32'(sent.size()), 32'h4);
		$display("test chain done");
		wreg(TDG_REG_CH_CFG, 32'h3);
		@(posedge clk);
		push(16'h0, 1'b0, 1'b0, 8'h1);
		pvld <= 1'b0;
		waitd(2, 3'h1);
		waitd(3, 3'h2);
		waitd(4, 3'h3);
		waitd(5, 3'h3);
		$display("test buffer done");
		for (int i = 0; i < 5; i++) begin
			u_mem.mem[13] = (i == 1) ? 32'h80000000 : 32'h80040000;
			u_mem.mem[14] = (i == 2) ? 32'h2 : 32'h1;
			abm <= (i == 3);
			ufm <= (i == 4);
			wreg(TDG_REG_CH_CFG, (i != 0) ? 32'h1 : 32'h0);
			@(posedge clk);
			push(16'h3, 1'b0, 1'b0, 8'h1);
			pvld <= 1'b0;
			waitd(6 + i, est[i]);
			rreg(TDG_REG_CH_CFG, 32'h0);
		end
		abm <= 1'b0;
		ufm <= 1'b0;
		u_mem.mem[14] = 32'h1;
		$display("test fault done");
		@(posedge clk);
		push(16'h3, 1'b0, 1'b0, 8'h1);
		push(16'h4, 1'b0, 1'b1, 8'h1);
		pvld <= 1'b0;
		waitd(11, 3'h4);
		waitd(12, 3'h0);
		rreg(TDG_REG_CH_CFG, 32'h1);
		$display("test restart done");
		sent.delete();
		@(posedge clk);
		push(16'h5, 1'b0, 1'b0, 8'h1);
		pvld <= 1'b0;
		while (!xo.valid) @(posedge clk);
		push(16'h7, 1'b1, 1'b0, 8'h1);
		push(16'h8, 1'b1, 1'b0, 8'h1);
		push(16'h9, 1'b1, 1'b0, 8'h1);
		pvld <= 1'b0;
		waitd(17, 3'h0);
		chk(u_mem.mem[35], 32'h00010009);
		for (int i = 0; i < 5; i++) chk(sent[i], ba(ord[i]));
		rreg(TDG_REG_DONE_BASE, 32'h800);
		rreg(TDG_REG_STATUS, 32'h12);
		$display("test urgent done");
		conclude();
	end
endmodule // tdg_tx_dma_tb
`default_nettype wire
